// >>> core/brake_pkg.sv
`default_nettype none
package brake_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ            = 250_000_000;
	localparam int unsigned WAIT_UNIT_MS      = 10;
	localparam int unsigned DELAY_UNIT_MS     = 1;
	localparam int unsigned WAIT_UNIT_CYCLES  = CLK_HZ / 1000 * WAIT_UNIT_MS;
	localparam int unsigned DELAY_UNIT_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;

	// Reset values of the settings
	localparam logic [15:0] SPEED_LEVEL_RST = 16'h0064;
	localparam logic [7:0]  WAIT_TIME_RST   = 8'h32;
	localparam logic [7:0]  DELAY_RST       = 8'h00;
	localparam logic [15:0] STOPPED_SPEED_RST = 16'h0000;

	// Register byte offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_DELAY  = 4'h4;
	localparam logic [3:0] OFS_SPEED  = 4'h8;
	localparam logic [3:0] OFS_WAIT   = 4'hC;

	// Field positions
	localparam int unsigned CTRL_STOPPED_LSB = 0;
	localparam int unsigned ST_BRAKE_BIT     = 16;
	localparam int unsigned ST_MOTOR_BIT     = 17;
	localparam int unsigned ST_STATE_LSB     = 20;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		S_RUN,
		S_OFF_DELAY,
		S_ROT_WAIT,
		S_OFF
	} brake_state_t;

	// Settings passed to the sequencer
	typedef struct packed {
		logic [7:0]  delay;
		logic [15:0] speed_level;
		logic [7:0]  wait_time;
		logic [15:0] stopped_speed;
	} brake_cfg_t;
endpackage : brake_pkg
`default_nettype wire

// >>> core/unit_tick.sv
`default_nettype none
module unit_tick
	import brake_pkg::*;
#(
	parameter int unsigned PERIOD = WAIT_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Restart the period and output a pulse at each end
	input  wire logic restart,
	output logic      tick
);
	localparam int unsigned W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
	logic [W-1:0] cnt;

	// Free divider, re-phased on restart so the first unit is whole
	always_ff @(posedge clk) begin
		if (srst || restart) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (cnt == W'(PERIOD - 1)) begin
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : unit_tick
`default_nettype wire

// >>> core/holding_brake_timing.sv
`default_nettype none
module holding_brake_timing
	import brake_pkg::*;
#(
	parameter int unsigned WAIT_TICK  = WAIT_UNIT_CYCLES,
	parameter int unsigned DELAY_TICK = DELAY_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Drive status inputs
	input  wire logic        servo_on,
	input  wire logic        alarm,
	input  wire logic        power_ok,
	input  wire logic [15:0] motor_speed,
	// Outputs to brake relay and power stage
	output logic             brake_release_out,
	output logic             motor_output_off,
	// AXI4-Lite slave
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	brake_cfg_t   cfg;
	brake_state_t state;
	logic [7:0]   cnt;
	logic         wtick;
	logic         dtick;
	logic         servo_req;
	logic         below;
	logic         aw_hold;
	logic         w_hold;
	logic [3:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;

	// Merge byte lanes into a 32-bit word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Any of the three servo-off causes removes the request
	assign servo_req = servo_on && !alarm && power_ok;
	assign below     = motor_speed < cfg.speed_level;

	// Unit ticks restart whenever the sequencer leaves run, so units are whole
	unit_tick #(.PERIOD(WAIT_TICK)) u_wait_tick (
		.clk     (clk),
		.srst    (srst),
		.restart (state == S_RUN),
		.tick    (wtick)
	);
	unit_tick #(.PERIOD(DELAY_TICK)) u_delay_tick (
		.clk     (clk),
		.srst    (srst),
		.restart (state == S_RUN),
		.tick    (dtick)
	);

	// Brake sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= S_OFF;
			cnt   <= 8'h00;
		end else begin
			unique case (state)
				S_RUN: begin
					cnt <= 8'h00;
					if (!servo_req) begin
						// Standstill picks the delay path, rotation the wait path
						if (motor_speed <= cfg.stopped_speed) begin
							state <= (cfg.delay == 8'h00) ? S_OFF : S_OFF_DELAY;
						end else begin
							state <= S_ROT_WAIT;
						end
					end
				end
				S_OFF_DELAY: begin
					if (servo_req) begin
						state <= S_RUN;
					end else if (dtick) begin
						cnt <= cnt + 8'h01;
						if (cnt + 8'h01 >= cfg.delay) begin
							state <= S_OFF;
						end
					end
				end
				S_ROT_WAIT: begin
					if (wtick) begin
						cnt <= cnt + 8'h01;
					end
					if (below || (wtick && cnt + 8'h01 >= cfg.wait_time)) begin
						state <= S_OFF;
					end
				end
				S_OFF: begin
					cnt <= 8'h00;
					if (servo_req) begin
						state <= S_RUN;
					end
				end
				default: state <= S_OFF;
			endcase
		end
	end

	// Output stage: high applies; the brake stays released through the rotating wait
	always_ff @(posedge clk) begin
		if (srst) begin
			brake_release_out <= 1'b1;
			motor_output_off  <= 1'b1;
		end else begin
			brake_release_out <= state == S_OFF_DELAY || !servo_req && (state == S_OFF
				|| state == S_RUN && motor_speed <= cfg.stopped_speed);
			motor_output_off  <= !servo_req && (state == S_OFF || state == S_RUN
				&& motor_speed <= cfg.stopped_speed && cfg.delay == 8'h00);
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			cfg     <= '{delay: DELAY_RST, speed_level: SPEED_LEVEL_RST,
				wait_time: WAIT_TIME_RST, stopped_speed: STOPPED_SPEED_RST};
		end else begin
			if (awvalid && awready) begin
				aw_hold <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (aw_hold && w_hold && !bvalid) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= RESP_OKAY;
				unique case (aw_addr)
					OFS_CTRL: cfg.stopped_speed <=
						16'(merge({16'h0000, cfg.stopped_speed}, w_data, w_strb));
					OFS_DELAY: cfg.delay <= 8'(merge({24'h0, cfg.delay}, w_data, w_strb));
					OFS_SPEED: cfg.speed_level <=
						16'(merge({16'h0000, cfg.speed_level}, w_data, w_strb));
					OFS_WAIT: cfg.wait_time <=
						8'(merge({24'h0, cfg.wait_time}, w_data, w_strb));
					default: bresp <= RESP_SLVERR;
				endcase
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Ready while the holding slot is empty and no write response is pending
	always_ff @(posedge clk) begin
		if (srst) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !aw_hold && !(awvalid && awready) && !bvalid;
			wready  <= !w_hold && !(wvalid && wready) && !bvalid;
		end
	end

	// Read channel, one cycle answer; status shows outputs and state
	always_ff @(posedge clk) begin
		if (srst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= RESP_OKAY;
				unique case (araddr)
					OFS_CTRL: begin
						rdata <= 32'h0000_0000;
						rdata[CTRL_STOPPED_LSB +: 16] <= cfg.stopped_speed;
						rdata[ST_BRAKE_BIT]           <= brake_release_out;
						rdata[ST_MOTOR_BIT]           <= motor_output_off;
						rdata[ST_STATE_LSB +: 3]      <= state;
					end
					OFS_DELAY: rdata <= {24'h0, cfg.delay};
					OFS_SPEED: rdata <= {16'h0000, cfg.speed_level};
					OFS_WAIT:  rdata <= {24'h0, cfg.wait_time};
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= RESP_SLVERR;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Released brake only while servo requested, or after a cycle in run or the rotating wait
	property p_release_needs_req;
		@(posedge clk) disable iff (srst)
		!brake_release_out |-> $past(servo_req) || $past(state) inside {S_RUN, S_ROT_WAIT};
	endproperty
	a_release_needs_req: assert property (p_release_needs_req)
		else $error("brake released without servo request");

	property p_below_applies;
		@(posedge clk) disable iff (srst)
		(state == S_ROT_WAIT && below) |=> ##1 brake_release_out;
	endproperty
	a_below_applies: assert property (p_below_applies)
		else $error("brake not applied below speed level");

	property p_zero_delay;
		@(posedge clk) disable iff (srst)
		(state == S_RUN && !servo_req && motor_speed <= cfg.stopped_speed && cfg.delay == 8'h00)
		|=> ##1 (brake_release_out && motor_output_off);
	endproperty
	a_zero_delay: assert property (p_zero_delay)
		else $error("zero delay did not stop motor with brake");

	property p_delay_holds_motor;
		@(posedge clk) disable iff (srst)
		(state == S_OFF_DELAY) |=> (brake_release_out && !motor_output_off);
	endproperty
	a_delay_holds_motor: assert property (p_delay_holds_motor)
		else $error("motor stopped before brake delay");

	property p_rot_path;
		@(posedge clk) disable iff (srst)
		(state == S_RUN && !servo_req && motor_speed > cfg.stopped_speed) |=> state == S_ROT_WAIT;
	endproperty
	a_rot_path: assert property (p_rot_path)
		else $error("rotating servo off missed wait path");

	property p_wait_expiry;
		@(posedge clk) disable iff (srst)
		(state == S_ROT_WAIT && wtick && cnt + 8'h01 >= cfg.wait_time) |=> state == S_OFF;
	endproperty
	a_wait_expiry: assert property (p_wait_expiry)
		else $error("wait expiry did not apply brake");

	property p_cleared_run;
		@(posedge clk) disable iff (srst)
		(state == S_RUN) |=> (cnt == 8'h00 || state != S_RUN);
	endproperty
	a_cleared_run: assert property (p_cleared_run)
		else $error("wait timer not cleared in run");

	property p_alarm_off;
		@(posedge clk) disable iff (srst)
		(alarm && state == S_RUN) |=> state != S_RUN;
	endproperty
	a_alarm_off: assert property (p_alarm_off)
		else $error("alarm did not leave run");
endmodule : holding_brake_timing
`default_nettype wire

// >>> dv/brake_relay_model.sv
`default_nettype none
module brake_relay_model #(
	parameter int unsigned LAG = 3
) (
	// Clock
	input  wire logic clk,
	// Relay contact from the drive
	input  wire logic brake_release_out,
	// Spring brake holding the shaft
	output logic      brake_engaged
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt;
	// Open contact drops the coil; the spring sets only after a mechanical lag
	always_ff @(posedge clk) begin
		if (brake_release_out) begin
			if (cnt < LAG)
				cnt <= cnt + 1;
			brake_engaged <= (cnt >= LAG - 1);
		end else begin
			cnt           <= 0;
			brake_engaged <= 1'b0;
		end
	end
endmodule : brake_relay_model
`default_nettype wire

// >>> dv/holding_brake_timing_bench.sv
`default_nettype none
module holding_brake_timing_bench
	import brake_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WT = 10;
	localparam int DT = 5;
	logic        clk, srst, servo_on, alarm, power_ok, bko, moff, held;
	logic [15:0] motor_speed;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] exp_q[$], msk_q[$];
	int          error_cnt, n_tests, n, seed, k;

	holding_brake_timing #(.WAIT_TICK(WT), .DELAY_TICK(DT)) i_holding_brake_timing (
		.clk(clk), .srst(srst), .servo_on(servo_on), .alarm(alarm), .power_ok(power_ok),
		.motor_speed(motor_speed), .brake_release_out(bko), .motor_output_off(moff),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	brake_relay_model i_brake_relay_model (.clk(clk), .brake_release_out(bko),
		.brake_engaged(held));

	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// Channels released one by one as each is taken; the write response awaited
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1));
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, {30'h0, r});
	endtask : wr

	// Expectation is noted first; the monitor compares when the data appear
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready && arvalid) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1));
		rready <= 1'b0;
	endtask : rd

	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
			check("rresp", {30'h0, rresp}, {30'h0, RESP_OKAY});
			// Both queues are read before either is shortened
			check("rdata", rdata & msk_q[0], exp_q[0] & msk_q[0]);
			exp_q.delete(0);
			msk_q.delete(0);
		end
	end

	// Cycles until the brake is applied, bounded
	task automatic wait_apply;
		n = 0;
		while (bko !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_apply

	task automatic run_on;
		@(posedge clk);
		servo_on <= 1'b1;
		alarm    <= 1'b0;
		power_ok <= 1'b1;
		repeat (6) @(posedge clk);
		check("released", {31'h0, bko}, 32'h0);
	endtask : run_on

	// Off cause: 0 servo-on drop, 1 alarm, 2 power loss
	task automatic go_off(input int c);
		@(posedge clk);
		servo_on <= (c != 0);
		alarm    <= (c == 1);
		power_ok <= (c != 2);
	endtask : go_off

	initial begin
		#(4 * 40000);
		error_cnt++;
		final_report;
	end

	initial begin
		seed = 73515;
		{srst, servo_on, alarm, power_ok} = 4'h9;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, motor_speed} = '0;
		repeat (8) @(posedge clk);
		srst  <= 1'b0;
		wstrb <= 4'hF;
		rd(OFS_DELAY, 32'h0, 32'hFF);
		rd(OFS_SPEED, 32'h64, 32'hFFFF);
		rd(OFS_WAIT, 32'h32, 32'hFF);
		rd(OFS_CTRL, 32'h0033_0000, 32'h0073_0000);
		// Unmapped offset must be refused without touching any setting
		wr(4'h2, 32'h5, RESP_SLVERR);
		run_on;
		rd(OFS_CTRL, 32'h0, 32'h0073_0000);
		// Standstill, default delay: both outputs move on the same edge
		go_off(0);
		wait_apply;
		check("same_edge", {31'h0, moff}, 32'h1);
		// Standstill with a delay of three units
		run_on;
		wr(OFS_DELAY, 32'h3, RESP_OKAY);
		go_off(0);
		wait_apply;
		for (k = 0; k < 40 && moff !== 1'b1; k++)
			@(posedge clk);
		check("delay_cyc", {31'h0, k >= 3 * DT && k <= 3 * DT + 2}, 32'h1);
		// Rotating, expiry of two wait units while speed stays high
		run_on;
		wr(OFS_WAIT, 32'h2, RESP_OKAY);
		motor_speed <= 16'd200 + 16'($random(seed) & 32'h3FF);
		go_off(0);
		wait_apply;
		check("wait_cyc", {31'h0, n >= 2 * WT - 1 && n <= 2 * WT + 4}, 32'h1);
		repeat (5) @(posedge clk);
		check("engaged", {31'h0, held}, 32'h1);
		// Rotating, speed falls below the level; every off cause
		wr(OFS_WAIT, 32'h32, RESP_OKAY);
		for (int c = 0; c < 3; c++) begin
			run_on;
			motor_speed <= 16'd200 + 16'($random(seed) & 32'h3FF);
			go_off(c);
			rd(OFS_CTRL, 32'h0020_0000, 32'h0071_0000);
			check("held_off", {31'h0, bko}, 32'h0);
			motor_speed <= 16'($random(seed) & 32'h3F);
			wait_apply;
			check("spd_cyc", {31'h0, n <= 4}, 32'h1);
		end
		motor_speed <= 16'h0000;
		run_on;
		repeat (4) @(posedge clk);
		final_report;
	end
endmodule : holding_brake_timing_bench
`default_nettype wire
